//--- common/ads_pkg.sv
package ads_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Transfer, burst, size and response codes
    localparam logic [1:0] TRANS_IDLE = 2'h0;
    localparam logic [1:0] TRANS_BUSY = 2'h1;
    localparam logic [1:0] TRANS_NONSEQ = 2'h2;
    localparam logic [1:0] TRANS_SEQ = 2'h3;

    localparam logic [2:0] BURST_SINGLE = 3'h0;
    localparam logic [2:0] BURST_INCR = 3'h1;
    localparam logic [2:0] BURST_WRAP4 = 3'h2;
    localparam logic [2:0] BURST_INCR4 = 3'h3;
    localparam logic [2:0] BURST_WRAP8 = 3'h4;
    localparam logic [2:0] BURST_INCR8 = 3'h5;
    localparam logic [2:0] BURST_WRAP16 = 3'h6;
    localparam logic [2:0] BURST_INCR16 = 3'h7;

    localparam logic [2:0] SIZE_32 = 3'h2;
    localparam logic [2:0] SIZE_64 = 3'h3;

    localparam logic RESP_OKAY = 1'b0;
    localparam logic RESP_ERROR = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int ADDR_HALF_BIT = 2;      // Word-select bit inside a 64-bit lane
    localparam int WRAP16_LO_BIT = 3;      // 128-byte wrap window of a 64-bit WRAP16
    localparam int WRAP16_HI_BIT = 6;
    localparam logic [3:0] WRAP16_START = 4'h0;

    // Reset values
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic wide_side_select;
        logic [31:0] wide_address;
        logic [1:0] wide_transfer_type;
        logic [2:0] wide_burst_code;
        logic [2:0] wide_size_code;
        logic [3:0] wide_protection;
        logic wide_lock;
        logic wide_direction;
    } ads_wide_ctrl_t;

    typedef struct packed {
        logic narrow_side_select;
        logic [31:0] narrow_address;
        logic [1:0] narrow_transfer_type;
        logic [2:0] narrow_burst_code;
        logic [2:0] narrow_size_code;
        logic [3:0] narrow_protection;
        logic narrow_lock;
        logic narrow_direction;
    } ads_narrow_ctrl_t;

    typedef enum logic [3:0] {
        ST_PASS = 4'h1,
        ST_HALF1 = 4'h2,
        ST_PEND = 4'h4,
        ST_BLOCK = 4'h8
    } ads_state_t;

    typedef struct packed {
        ads_state_t st;
        logic dp_act;
        logic dp_hi;
        logic dp_64hi;
        logic dp_b64;
        logic dp_blk;
        logic err1;
        ads_wide_ctrl_t cap;
        logic [31:0] low_word;
    } ads_core_t;

endpackage : ads_pkg

//--- verilog/ads_ctrl_map.sv
`timescale 1ns/1ps
`default_nettype none

module ads_ctrl_map (
    input wire ads_pkg::ads_wide_ctrl_t wide_ctrl,
    output ads_pkg::ads_narrow_ctrl_t narrow_ctrl
);
    import ads_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Copy the control word, then rework size, burst and wrap for 64-bit beats
    always_comb begin
        narrow_ctrl.narrow_side_select = wide_ctrl.wide_side_select;
        narrow_ctrl.narrow_address = wide_ctrl.wide_address;
        narrow_ctrl.narrow_transfer_type = wide_ctrl.wide_transfer_type;
        narrow_ctrl.narrow_burst_code = wide_ctrl.wide_burst_code;
        narrow_ctrl.narrow_size_code = wide_ctrl.wide_size_code;
        narrow_ctrl.narrow_protection = wide_ctrl.wide_protection;   // [R4]
        narrow_ctrl.narrow_lock = wide_ctrl.wide_lock;               // [R4]
        narrow_ctrl.narrow_direction = wide_ctrl.wide_direction;     // [R4]
        if (wide_ctrl.wide_size_code == SIZE_64) begin
            narrow_ctrl.narrow_size_code = SIZE_32;                  // [R18]
            case (wide_ctrl.wide_burst_code)
                BURST_SINGLE: narrow_ctrl.narrow_burst_code = BURST_INCR;   // [R18]
                BURST_INCR4: narrow_ctrl.narrow_burst_code = BURST_INCR8;   // [R18]
                BURST_WRAP4: narrow_ctrl.narrow_burst_code = BURST_WRAP8;   // [R18]
                BURST_INCR8: narrow_ctrl.narrow_burst_code = BURST_INCR16;  // [R18]
                BURST_WRAP8: narrow_ctrl.narrow_burst_code = BURST_WRAP16;  // [R18]
                BURST_WRAP16: narrow_ctrl.narrow_burst_code = BURST_INCR;   // [R18]
                BURST_INCR16: narrow_ctrl.narrow_burst_code = BURST_INCR;   // Length unknown
                default: narrow_ctrl.narrow_burst_code = BURST_INCR;
            endcase
            // A wrapped WRAP16 beat jumps back, so the narrow bus restarts
            if (wide_ctrl.wide_burst_code == BURST_WRAP16 &&
                wide_ctrl.wide_transfer_type == TRANS_SEQ &&
                wide_ctrl.wide_address[WRAP16_HI_BIT:WRAP16_LO_BIT] == WRAP16_START) begin
                narrow_ctrl.narrow_transfer_type = TRANS_NONSEQ;
            end
        end
    end

endmodule : ads_ctrl_map

`default_nettype wire

//--- verilog/ads_downsizer.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1: Rising-edge state, async active-low reset clears.
// R2: Wide port: address, burst, size, protection, 64-bit data.
// R3: Narrow port: address, data, read data, ready, response.
// R4: Forward lock, protection, size, burst, direction narrow.
// R5: Wide select means narrow range addressed.
// R6: Wide ready marks transfers; sample control only then.
// R7: Wide ready-out low inserts waits, high when ready.
// R8: Narrow select high whenever narrow bus accessed.
// R9: Narrow ready follows slave when selected, else wide.
// R10: Narrow slaves use bridge narrow ready only.
// R11: Unselected narrow slave answers ready high, OKAY.
// R12: 64-bit transfer becomes two 32-bit transfers.
// R13: First half ready hidden; wide waits for second.
// R14: Multiple narrow slaves decode from narrow select.
// R15: Low word latched first, second beat upper word.
// R16: Error passed at once; skips second half.
// R17: Post-error burst: SEQ gets ERROR, BUSY OKAY.
// R18: 64-bit size/burst remapped; narrower pass unchanged.
// R19: Unselected: ready high, OKAY, narrow select low.
module ads_downsizer (
    input wire logic clk,
    input wire logic reset_n,
    input wire ads_pkg::ads_wide_ctrl_t wide_ctrl,
    input wire logic wide_bus_ready_in,
    input wire logic [63:0] wide_write_data,
    output logic [63:0] wide_read_data,
    output logic wide_side_ready_out,
    output logic wide_side_response,
    output ads_pkg::ads_narrow_ctrl_t narrow_ctrl,
    output logic [31:0] narrow_write_data,
    output logic narrow_side_ready_out,
    input wire logic [31:0] narrow_read_data,
    input wire logic narrow_slave_ready_in,
    input wire logic narrow_slave_response
);
    import ads_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    ads_core_t s_reg;
    ads_core_t s_next;
    ads_narrow_ctrl_t live_map;
    ads_narrow_ctrl_t cap_map;
    logic nerr;
    logic sel_narrow;
    logic take_new;
    logic err_exit;
    logic wide_is64;
    logic wide_valid;

    ////////////////////////////////////////////////////////////////////////////
    // Control mapping for the live wide request and the captured one
    ads_ctrl_map u_live_map (
        .wide_ctrl(wide_ctrl),
        .narrow_ctrl(live_map)
    );

    ads_ctrl_map u_cap_map (
        .wide_ctrl(s_reg.cap),
        .narrow_ctrl(cap_map)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Data lanes: write data stays stable over both halves, so no register
    always_comb begin
        narrow_write_data = s_reg.dp_hi ? wide_write_data[63:32] : wide_write_data[31:0]; // [R3]
        if (s_reg.dp_64hi) begin
            wide_read_data = {narrow_read_data, s_reg.low_word};       // [R15]
        end else begin
            wide_read_data = {narrow_read_data, narrow_read_data};     // [R2]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state and bus outputs
    always_comb begin
        s_next = s_reg;
        take_new = 1'b0;
        err_exit = 1'b0;
        wide_is64 = (wide_ctrl.wide_size_code == SIZE_64);
        wide_valid = wide_ctrl.wide_side_select && wide_ctrl.wide_transfer_type[1]; // [R5]
        nerr = s_reg.dp_act && (narrow_slave_response == RESP_ERROR);
        sel_narrow = s_reg.dp_act || s_reg.st == ST_HALF1 || s_reg.st == ST_PEND;
        // Default: narrow address phase passes through, 32-bit and smaller unchanged
        narrow_ctrl = live_map;                                         // [R8] [R18]
        wide_side_ready_out = 1'b1;                                     // [R19]
        wide_side_response = RESP_OKAY;                                 // [R19]
        if (s_reg.dp_act) begin
            wide_side_ready_out = narrow_slave_ready_in;                // [R7]
            wide_side_response = narrow_slave_response;                 // [R16]
        end
        // Narrow ready follows the slave while our transfer owns the bus
        narrow_side_ready_out = sel_narrow ? narrow_slave_ready_in : wide_bus_ready_in; // [R9]
        case (s_reg.st)
            ST_PASS: begin
                if (nerr) begin
                    narrow_ctrl.narrow_transfer_type = TRANS_IDLE;      // [R16]
                    err_exit = narrow_slave_ready_in;
                end else if (narrow_side_ready_out) begin
                    take_new = 1'b1;                                    // [R6]
                end
            end
            ST_HALF1: begin
                // Second-half address phase overlaps the first-half data phase
                narrow_ctrl = cap_map;
                narrow_ctrl.narrow_side_select = 1'b1;                  // [R8]
                narrow_ctrl.narrow_address[ADDR_HALF_BIT] = 1'b1;       // [R12]
                narrow_ctrl.narrow_transfer_type = TRANS_SEQ;           // [R12]
                if (nerr) begin
                    narrow_ctrl.narrow_transfer_type = TRANS_IDLE;      // [R16]
                    err_exit = narrow_slave_ready_in;
                end else begin
                    wide_side_ready_out = 1'b0;                         // [R13]
                    if (narrow_slave_ready_in) begin
                        s_next.low_word = narrow_read_data;             // [R15]
                        s_next.st = ST_PASS;
                        s_next.dp_hi = 1'b1;
                        s_next.dp_64hi = 1'b1;
                    end
                end
            end
            ST_PEND: begin
                // Replay a request that met an aborted narrow cycle
                narrow_ctrl = cap_map;
                narrow_ctrl.narrow_side_select = 1'b1;
                narrow_ctrl.narrow_transfer_type = TRANS_NONSEQ;
                wide_side_ready_out = 1'b0;                             // [R7]
                if (narrow_slave_ready_in) begin
                    s_next.dp_act = 1'b1;
                    s_next.dp_hi = s_reg.cap.wide_address[ADDR_HALF_BIT];
                    s_next.dp_64hi = 1'b0;
                    s_next.dp_b64 = (s_reg.cap.wide_size_code == SIZE_64) &&
                                    (s_reg.cap.wide_burst_code != BURST_SINGLE);
                    s_next.st = (s_reg.cap.wide_size_code == SIZE_64) ? ST_HALF1 : ST_PASS;
                end
            end
            ST_BLOCK: begin
                // Burst blocked: narrow bus sees IDLE, wide beats get answered here
                narrow_ctrl.narrow_side_select = 1'b0;
                narrow_ctrl.narrow_transfer_type = TRANS_IDLE;          // [R17]
                if (s_reg.dp_blk) begin
                    wide_side_response = RESP_ERROR;                    // [R17]
                    wide_side_ready_out = s_reg.err1;
                    s_next.err1 = ~s_reg.err1;
                end
                if (wide_side_ready_out && wide_bus_ready_in) begin
                    s_next.dp_blk = 1'b0;
                    if (!wide_ctrl.wide_side_select ||
                        wide_ctrl.wide_transfer_type == TRANS_IDLE) begin
                        s_next.st = ST_PASS;                            // [R17]
                    end else if (wide_ctrl.wide_transfer_type == TRANS_NONSEQ) begin
                        s_next.st = ST_PEND;                            // [R17]
                        s_next.cap = wide_ctrl;
                    end else begin
                        s_next.dp_blk = (wide_ctrl.wide_transfer_type == TRANS_SEQ); // [R17]
                    end
                end
            end
            default: begin
                s_next.st = ST_PASS;
            end
        endcase
        // New address phase accepted by both buses together
        if (take_new) begin
            s_next.cap = wide_ctrl;                                     // [R6]
            s_next.dp_act = wide_valid;
            s_next.dp_hi = wide_ctrl.wide_address[ADDR_HALF_BIT];
            s_next.dp_64hi = 1'b0;
            s_next.dp_b64 = wide_is64 && (wide_ctrl.wide_burst_code != BURST_SINGLE);
            if (wide_valid && wide_is64) begin
                s_next.st = ST_HALF1;                                   // [R12]
            end
        end
        // End of a two-cycle error: block the burst or park the next request
        if (err_exit) begin
            s_next.dp_act = 1'b0;
            s_next.dp_64hi = 1'b0;
            s_next.err1 = 1'b0;
            s_next.dp_blk = 1'b0;
            s_next.st = ST_PASS;
            if (s_reg.dp_b64 && wide_ctrl.wide_side_select &&
                (wide_ctrl.wide_transfer_type == TRANS_SEQ ||
                 wide_ctrl.wide_transfer_type == TRANS_BUSY)) begin
                s_next.st = ST_BLOCK;                                   // [R17]
                s_next.dp_blk = (wide_ctrl.wide_transfer_type == TRANS_SEQ);
            end else if (wide_valid) begin
                s_next.st = ST_PEND;                                    // [R16]
                s_next.cap = wide_ctrl;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or negedge reset_n) begin                   // [R1]
        if (!reset_n) begin
            s_reg.st <= ST_PASS;
            s_reg.dp_act <= 1'b0;
            s_reg.dp_hi <= 1'b0;
            s_reg.dp_64hi <= 1'b0;
            s_reg.dp_b64 <= 1'b0;
            s_reg.dp_blk <= 1'b0;
            s_reg.err1 <= 1'b0;
            s_reg.cap <= '0;
            s_reg.low_word <= WORD_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule : ads_downsizer

`default_nettype wire

//--- dv/ads_downsizer_props.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the bridge ports for the split, mapping, error and idle behaviour
module ads_downsizer_props (
    input wire logic clk,
    input wire logic reset_n,
    input wire ads_pkg::ads_wide_ctrl_t wide_ctrl,
    input wire logic wide_bus_ready_in,
    input wire logic [63:0] wide_read_data,
    input wire logic wide_side_ready_out,
    input wire logic wide_side_response,
    input wire ads_pkg::ads_narrow_ctrl_t narrow_ctrl,
    input wire logic narrow_side_ready_out,
    input wire logic [31:0] narrow_read_data,
    input wire logic narrow_slave_ready_in,
    input wire logic narrow_slave_response
);
    import ads_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic rdy, err, w64, take;
    ////////////////////////////////////////////////////////////////////////////
    // Shorthand for the wide answer and an accepted 64-bit wide NONSEQ
    assign rdy = wide_side_ready_out;
    assign err = wide_side_response;
    assign w64 = wide_ctrl.wide_side_select && wide_ctrl.wide_size_code == SIZE_64;
    assign take = w64 && wide_ctrl.wide_transfer_type == TRANS_NONSEQ && rdy && !err;
    // Expected narrow burst code of a wide transfer
    function automatic logic [2:0] map_burst(input logic [2:0] b);
        case (b)
            BURST_SINGLE, BURST_WRAP16, BURST_INCR16: return BURST_INCR;
            BURST_INCR4: return BURST_INCR8;
            BURST_WRAP4: return BURST_WRAP8;
            BURST_INCR8: return BURST_INCR16;
            BURST_WRAP8: return BURST_WRAP16;
            default: return b;
        endcase
    endfunction : map_burst
    ////////////////////////////////////////////////////////////////////////////
    a_idle_quiet: assert property (
        $past(!wide_ctrl.wide_side_select && wide_bus_ready_in && rdy) |-> rdy && !err
        && narrow_side_ready_out == wide_bus_ready_in
        && (wide_ctrl.wide_side_select || !narrow_ctrl.narrow_side_select))
        else $error("bridge busy while unselected");
    a_half_two: assert property (
        take ##1 !narrow_slave_response |-> !rdy && narrow_ctrl.narrow_side_select
        && narrow_ctrl.narrow_transfer_type == TRANS_SEQ
        && narrow_ctrl.narrow_address == ($past(wide_ctrl.wide_address) | 32'h0000_0004)
        && narrow_ctrl.narrow_direction == $past(wide_ctrl.wide_direction)
        && narrow_side_ready_out == narrow_slave_ready_in)
        else $error("second narrow half wrong");
    a_ctrl_map: assert property (
        wide_ctrl.wide_side_select && wide_ctrl.wide_transfer_type == TRANS_NONSEQ && rdy
        && !err |-> narrow_ctrl.narrow_side_select
        && narrow_ctrl.narrow_address == wide_ctrl.wide_address
        && narrow_ctrl.narrow_protection == wide_ctrl.wide_protection
        && narrow_ctrl.narrow_lock == wide_ctrl.wide_lock
        && narrow_ctrl.narrow_size_code == (w64 ? SIZE_32 : wide_ctrl.wide_size_code)
        && narrow_ctrl.narrow_burst_code
        == (w64 ? map_burst(wide_ctrl.wide_burst_code) : wide_ctrl.wide_burst_code))
        else $error("narrow control not mapped");
    a_read_merge: assert property (
        take && !wide_ctrl.wide_direction ##1 narrow_slave_ready_in && !narrow_slave_response
        ##1 narrow_slave_ready_in |-> wide_read_data == {narrow_read_data,
        $past(narrow_read_data)})
        else $error("wide read data not merged");
    a_error_pass: assert property (
        narrow_slave_response |-> err && rdy == narrow_slave_ready_in)
        else $error("narrow error not passed");
    a_error_skip: assert property (
        narrow_slave_response && !narrow_slave_ready_in
        |-> narrow_ctrl.narrow_transfer_type == TRANS_IDLE ##1 err && rdy)
        else $error("narrow bus not idled on error");
    a_block_seq: assert property (
        $past(err && rdy && w64 && wide_ctrl.wide_transfer_type == TRANS_SEQ)
        |-> err && !rdy && !narrow_ctrl.narrow_side_select ##1 err && rdy)
        else $error("burst not blocked after error");
    a_busy_okay: assert property (
        $past(rdy && wide_ctrl.wide_side_select && wide_ctrl.wide_transfer_type == TRANS_BUSY)
        |-> rdy && !err)
        else $error("busy beat not answered okay");
    a_wrap_restart: assert property (
        w64 && wide_ctrl.wide_burst_code == BURST_WRAP16
        && wide_ctrl.wide_transfer_type == TRANS_SEQ
        && wide_ctrl.wide_address[WRAP16_HI_BIT:WRAP16_LO_BIT] == WRAP16_START
        && rdy && !err && narrow_ctrl.narrow_side_select
        |-> narrow_ctrl.narrow_transfer_type == TRANS_NONSEQ)
        else $error("wrap restart not nonsequential");
endmodule : ads_downsizer_props
`default_nettype wire

//--- dv/ads_narrow_slave.sv
`timescale 1ns/1ps
`default_nettype none
// Narrow slave with a memory, random waits and a two-cycle error at one address
module ads_narrow_slave (
    input wire logic clk,
    input wire logic reset_n,
    input wire ads_pkg::ads_narrow_ctrl_t narrow_ctrl,
    input wire logic narrow_side_ready_out,
    input wire logic [31:0] narrow_write_data,
    input wire logic [1:0] waits,
    input wire logic [31:0] err_addr,
    output logic [31:0] narrow_read_data,
    output logic narrow_slave_ready_in,
    output logic narrow_slave_response
);
    import ads_pkg::*;
    logic [31:0] mem [logic [31:0]];
    logic act, wr, eph, hit;
    logic [1:0] cnt;
    logic [31:0] adr, rdv, last;
    // Data phases advance on the bridge's narrow ready only
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            act <= 1'b0;
            eph <= 1'b0;
            last <= 32'h0;
        end else begin
            last <= narrow_read_data;
            if (narrow_side_ready_out) begin
                if (act && wr && !hit) mem[adr] = narrow_write_data;
                act <= narrow_ctrl.narrow_side_select && narrow_ctrl.narrow_transfer_type[1];
                adr <= narrow_ctrl.narrow_address;
                wr <= narrow_ctrl.narrow_direction;
                rdv <= mem.exists(narrow_ctrl.narrow_address) ? mem[narrow_ctrl.narrow_address]
                    : {narrow_ctrl.narrow_address[15:0], ~narrow_ctrl.narrow_address[15:0]};
                cnt <= waits;
                eph <= 1'b0;
            end else if (hit) begin
                eph <= 1'b1;
            end else if (cnt != 2'h0) begin
                cnt <= cnt - 2'h1;
            end
        end
    end
    // Outside a data phase: ready high, OKAY, read lines toggling
    assign hit = act && adr == err_addr;
    assign narrow_slave_ready_in = !act || (hit ? eph : cnt == 2'h0);
    assign narrow_slave_response = hit;
    assign narrow_read_data = (act && !wr) ? rdv : ~last;
endmodule : ads_narrow_slave
`default_nettype wire

//--- dv/ads_downsizer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ads_downsizer_tb;
    import ads_pkg::*;
    `define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin miscompares++; \
        $display("mismatch %s expected %h seen %h", n, e, s); end end
    logic clk, reset_n, ext_wait, wide_bus_ready_in, wide_side_ready_out, wide_side_response;
    logic narrow_side_ready_out, narrow_slave_ready_in, narrow_slave_response, dph;
    ads_wide_ctrl_t wide_ctrl;
    ads_narrow_ctrl_t narrow_ctrl;
    logic [63:0] wide_write_data, wide_read_data;
    logic [31:0] narrow_write_data, narrow_read_data, err_addr;
    logic [1:0] waits;
    logic [65:0] expq [$];
    logic [65:0] e;
    logic [31:0] tm [logic [31:0]];
    int miscompares, total_checks;
    ////////////////////////////////////////////////////////////////////////////
    ads_downsizer dut (.clk, .reset_n, .wide_ctrl, .wide_bus_ready_in, .wide_write_data,
        .wide_read_data, .wide_side_ready_out, .wide_side_response, .narrow_ctrl,
        .narrow_write_data, .narrow_side_ready_out, .narrow_read_data, .narrow_slave_ready_in,
        .narrow_slave_response);
    ads_narrow_slave slv (.clk, .reset_n, .narrow_ctrl, .narrow_side_ready_out,
        .narrow_write_data, .waits, .err_addr, .narrow_read_data, .narrow_slave_ready_in,
        .narrow_slave_response);
    // Another wide slave may stretch idle cycles
    assign wide_bus_ready_in = wide_side_ready_out & ~ext_wait;
    // Bus clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Expected narrow word at an address
    function automatic logic [31:0] val(input logic [31:0] a);
        return tm.exists(a) ? tm[a] : {a[15:0], ~a[15:0]};
    endfunction : val
    // Presents one wide request, holds it until accepted and notes the answer due
    task automatic xfer(input logic [1:0] t, input logic [31:0] a, input logic [2:0] sz,
            input logic [2:0] b, input logic w, input logic [63:0] wd, input logic er);
        logic [63:0] rd;
        wide_ctrl <= '{1'b1, a, t, b, sz, 4'($urandom), a[7], w};
        waits <= w ? 2'($urandom_range(2)) : 2'h0;
        rd = {val(sz == SIZE_64 ? a | 32'h4 : a), val(a)};
        do @(posedge clk); while (!wide_bus_ready_in);
        wide_write_data <= wd;
        if (w && !er) tm[a] = wd[31:0];
        if (w && !er) tm[a | 32'h4] = wd[63:32];
        if (t[1]) expq.push_back({er, !w && !er, rd});
    endtask : xfer
    // Deselects, lets the answers drain, then stretches idle cycles
    task automatic idle(input string name);
        wide_ctrl <= '0;
        for (int i = 0; i < 40 && expq.size() != 0; i++) @(posedge clk);
        `CHK("queue drained", 0, expq.size())
        ext_wait <= 1'b1;
        repeat (3) @(posedge clk);
        ext_wait <= 1'b0;
        @(posedge clk);
        $display("test %s done", name);
    endtask : idle
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////
    // Takes the oldest note as each wide data phase completes
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dph <= 1'b0;
        end else if (wide_bus_ready_in) begin
            if (dph) begin
                e = expq.pop_front();
                `CHK("response", e[65], wide_side_response)
                if (e[64]) `CHK("read data", e[63:0], wide_read_data)
            end
            dph <= wide_ctrl.wide_side_select && wide_ctrl.wide_transfer_type[1];
        end
    end
    // Main sequence
    initial begin
        logic [31:0] a;
        logic [63:0] d;
        reset_n = 1'b0;
        ext_wait = 1'b0;
        wide_ctrl = '0;
        wide_write_data = 64'h0;
        waits = 2'h0;
        err_addr = 32'hFFFF_FFFC;
        miscompares = 0;
        total_checks = 0;
        void'($urandom(32'hCA94));
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        // Every burst code: wide write, wide read back, narrow read of the upper word
        for (int b = 0; b < 8; b++) begin
            a = $urandom & 32'h0000_FFF8;
            d = {$urandom, $urandom};
            xfer(TRANS_NONSEQ, a, SIZE_64, 3'(b), 1'b1, d, 1'b0);
            xfer(TRANS_NONSEQ, a, SIZE_64, 3'(b), 1'b0, 64'h0, 1'b0);
            xfer(TRANS_NONSEQ, a | 32'h4, SIZE_32, 3'(b), 1'b0, 64'h0, 1'b0);
        end
        // Wrapping burst that returns to the start of its window
        xfer(TRANS_NONSEQ, 32'h0000_4078, SIZE_64, BURST_WRAP16, 1'b0, 64'h0, 1'b0);
        xfer(TRANS_SEQ, 32'h0000_4000, SIZE_64, BURST_WRAP16, 1'b0, 64'h0, 1'b0);
        idle("wide transfers");
        // Error on a burst beat, blocked beats around a busy beat, then a fresh read
        a = 32'h0000_2000;
        err_addr <= 32'h0000_2008;
        d = {$urandom, $urandom};
        xfer(TRANS_NONSEQ, a, SIZE_64, BURST_INCR4, 1'b1, d, 1'b0);
        xfer(TRANS_SEQ, a + 8, SIZE_64, BURST_INCR4, 1'b1, d, 1'b1);
        xfer(TRANS_SEQ, a + 16, SIZE_64, BURST_INCR4, 1'b1, d, 1'b1);
        xfer(TRANS_BUSY, a + 24, SIZE_64, BURST_INCR4, 1'b1, d, 1'b0);
        xfer(TRANS_SEQ, a + 24, SIZE_64, BURST_INCR4, 1'b1, d, 1'b1);
        xfer(TRANS_NONSEQ, a, SIZE_64, BURST_SINGLE, 1'b0, 64'h0, 1'b0);
        idle("burst error");
        // Narrow error is not followed by blocking
        err_addr <= 32'h0000_3004;
        xfer(TRANS_NONSEQ, 32'h0000_3004, SIZE_32, BURST_INCR, 1'b0, 64'h0, 1'b1);
        xfer(TRANS_SEQ, 32'h0000_3008, SIZE_32, BURST_INCR, 1'b0, 64'h0, 1'b0);
        idle("narrow error");
        report_and_stop();
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
endmodule : ads_downsizer_tb
bind ads_downsizer ads_downsizer_props chk (.clk, .reset_n, .wide_ctrl, .wide_bus_ready_in,
    .wide_read_data, .wide_side_ready_out, .wide_side_response, .narrow_ctrl,
    .narrow_side_ready_out, .narrow_read_data, .narrow_slave_ready_in, .narrow_slave_response);
`default_nettype wire
